// ==== pkg/atacf_pkg.sv ====
// package for the ata command register front end
// assumes the task-file bus has three address lines and two chip selects
package atacf_pkg;
	// task-file addresses (cs0 block / cs1 block)
	localparam logic [2:0] ADDR_ERROR     = 3'h1;
	localparam logic [2:0] ADDR_SECCNT    = 3'h2;
	localparam logic [2:0] ADDR_SECNUM    = 3'h3;
	localparam logic [2:0] ADDR_CYL_LO    = 3'h4;
	localparam logic [2:0] ADDR_CYL_HI    = 3'h5;
	localparam logic [2:0] ADDR_DRVHEAD   = 3'h6;
	localparam logic [2:0] ADDR_STATUS    = 3'h7;
	localparam logic [2:0] ADDR_CMD_ENTRY = 3'h7;
	localparam logic [2:0] ADDR_FEATURE   = 3'h1;
	localparam logic [2:0] ADDR_ALT_STAT  = 3'h6;
	localparam logic [2:0] ADDR_DEV_CTRL  = 3'h6;
	// device control fields
	localparam int DC_HOB  = 7;
	localparam int DC_SRST = 2;
	localparam int DC_NIEN = 1;
	// drive/head fields
	localparam int DH_DRIVE = 4;
	// status fields
	localparam int ST_BSY  = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DSC  = 4;
	localparam int ST_DRQ  = 3;
	localparam int ST_ERR  = 0;
	localparam int ER_ABRT = 2;
	// reset values
	localparam logic [7:0] DEV_CTRL_RST = 8'h08;
	localparam logic [7:0] DRVHEAD_RST  = 8'hA0;
	localparam logic [7:0] SECCNT_RST   = 8'h01;
	// decode classes: which parameters the opcode consumes
	typedef enum logic [2:0] {
		ATACF_CL_BAD    = 3'h0, // unknown code, aborted
		ATACF_CL_DRVONL = 3'h1, // drive select only
		ATACF_CL_XFER   = 3'h2, // full address + count
		ATACF_CL_CYLHD  = 3'h3, // cylinder + head
		ATACF_CL_COUNT  = 3'h4, // sector count argument
		ATACF_CL_FEAT   = 3'h5, // feature subcommand
		ATACF_CL_CNTSN  = 3'h6  // count + sector number
	} atacf_class_e;
	// command engine states, gray along idle-busy-done
	typedef enum logic [1:0] {
		ATACF_IDLE = 2'b00,
		ATACF_BUSY = 2'b01,
		ATACF_DONE = 2'b11
	} atacf_state_e;
endpackage : atacf_pkg

// ==== verilog/atacf_front_end.sv ====
// command-entry front end of the drive task file
// assumes cs/da/strobes come from the host cable (async, synchronised here)
// and command execution lives in a back end using the start/done handshake
`timescale 1ns/10ps

// Notes on behaviour
// R1 - start only on command write, idle and ready
// R2 - host writes command only when idle, ready
// R3 - unknown opcode ends in aborted command
// R4 - command write drops pending interrupt
// R5 - decode 28-bit transfer opcodes, paired codes
// R6 - decode 48-bit extended opcodes
// R7 - read verify pair and extended code
// R8 - power controls under two opcodes each
// R9 - host loads required task-file parameters
// R10 - nop, recalibrate, diagnostics use drive only
// R11 - drive from bit 4, head low nibble
// R12 - seek, format use cylinder, drive, head
// R13 - count argument commands use sector count
// R14 - subcommand commands use features register
// R15 - set max uses complete address
// R16 - alternate status read keeps interrupt
// R17 - command block write clears hob
// R18 - soft reset holds busy, resets registers
// R19 - soft reset hits both drives always
// R20 - enabled and selected drives interrupt pin
// R21 - disabled interrupt floats the pin
// R22 - host writes one to reserved bit
// R23 - status read acknowledges interrupt
// R24 - drive bit zero first, one second
// R25 - busy from command write to done; the code also clears busy early on cmd_drq
// R26 - abort sets err, abrt, clears busy, interrupts
// R27 - command write while busy is dropped
module atacf_front_end #(
	parameter bit DRIVE_ID = 1'b0 // 0 first drive, 1 second
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// task-file bus from host cable
	input  wire logic                 cs0_b,
	input  wire logic                 cs1_b,
	input  wire logic [2:0]           da,
	input  wire logic                 dior_b,
	input  wire logic                 diow_b,
	input  wire logic [7:0]           dd_in,
	output logic      [7:0]           dd_out,
	output logic                      dd_oe,
	// interrupt pin, two signals
	output logic                      intrq_out,
	output logic                      intrq_oe,
	// drive condition
	input  wire logic                 drive_ready,
	// back end handshake
	output logic                      cmd_start,
	output logic      [7:0]           cmd_opcode,
	output atacf_pkg::atacf_class_e   cmd_class,
	output logic      [27:0]          cmd_address,
	output logic      [7:0]           cmd_count,
	output logic      [7:0]           cmd_feature,
	output logic                      cmd_hob,
	output logic                      soft_reset,
	input  wire logic                 cmd_done,
	input  wire logic                 cmd_error,
	input  wire logic                 cmd_drq
);
	import atacf_pkg::*;

	// opcode decode into parameter class
	function automatic atacf_class_e decode_op(input logic [7:0] op);
		atacf_class_e c;
		c = ATACF_CL_BAD;
		unique casez (op)
			8'h00, 8'b0001_????, 8'h90: c = ATACF_CL_DRVONL; // R10
			8'h20, 8'h21, 8'h30, 8'h31,
			8'hC4, 8'hC5, 8'hC8, 8'hC9,
			8'hCA, 8'hCB, 8'h3C:       c = ATACF_CL_XFER; // R5
			8'h24, 8'h25, 8'h29, 8'h34,
			8'h35, 8'h39:              c = ATACF_CL_XFER; // R6
			8'h37, 8'hF9:              c = ATACF_CL_XFER; // R15
			8'h40, 8'h41, 8'h42:       c = ATACF_CL_XFER; // R7
			8'h27, 8'hF8, 8'hE4, 8'hE7,
			8'hE8, 8'hEA, 8'hEC, 8'hF1,
			8'hF2, 8'hF3, 8'hF4, 8'hF5,
			8'hF6:                     c = ATACF_CL_DRVONL; // R6
			8'h50, 8'b0111_????:       c = ATACF_CL_CYLHD; // R12
			8'h91, 8'hC6:              c = ATACF_CL_COUNT; // R13
			8'hE0, 8'hE1, 8'hE2, 8'hE3,
			8'hE5, 8'hE6, 8'h94, 8'h95,
			8'h96, 8'h97, 8'h98, 8'h99: c = ATACF_CL_COUNT; // R8
			8'hEF, 8'hB0, 8'hB1, 8'hFC: c = ATACF_CL_FEAT; // R14
			8'h92:                     c = ATACF_CL_CNTSN;
			default:                   c = ATACF_CL_BAD; // R3
		endcase
		return c;
	endfunction : decode_op

	// two-flop synchronisers for the cable inputs
	logic [14:0] sync1;
	logic [14:0] sync2;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= 15'h7FFF;
			sync2 <= 15'h7FFF;
		end else begin
			sync1 <= {cs0_b, cs1_b, da, dior_b, diow_b, dd_in};
			sync2 <= sync1;
		end
	end

	logic       s_cs0_b, s_cs1_b, s_rd_b, s_wr_b;
	logic [2:0] s_da;
	logic [7:0] s_dd;
	assign {s_cs0_b, s_cs1_b, s_da, s_rd_b, s_wr_b, s_dd} = sync2;

	// strobe edge detect on the synchronised copies only
	logic rd_q, wr_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= 1'b1;
			wr_q <= 1'b1;
		end else begin
			rd_q <= s_rd_b;
			wr_q <= s_wr_b;
		end
	end

	logic wr_pulse, rd_pulse, blk0, blk1;
	assign wr_pulse = wr_q && !s_wr_b;
	assign rd_pulse = rd_q && !s_rd_b;
	assign blk0     = !s_cs0_b && s_cs1_b;
	assign blk1     = s_cs0_b && !s_cs1_b;

	logic wr_cmd, wr_ctrl, wr_blk0, rd_stat;
	assign wr_blk0 = wr_pulse && blk0;
	assign wr_cmd  = wr_blk0 && s_da == ADDR_CMD_ENTRY;
	assign wr_ctrl = wr_pulse && blk1 && s_da == ADDR_DEV_CTRL;
	assign rd_stat = rd_pulse && blk0 && s_da == ADDR_STATUS;

	// task-file registers and engine state
	logic [7:0]   dev_ctrl, next_dev_ctrl;
	logic [7:0]   seccnt, next_seccnt, secnum, next_secnum;
	logic [7:0]   cyl_lo, next_cyl_lo, cyl_hi, next_cyl_hi;
	logic [7:0]   drvhead, next_drvhead, feature, next_feature;
	logic [7:0]   status, next_status, error, next_error;
	logic         irq_pend, next_irq_pend;
	atacf_state_e state, next_state;
	logic         next_start;
	logic [7:0]   next_opcode;
	atacf_class_e next_class;
	logic         srst, selected;

	// soft reset is the same for both drives, no select check
	assign srst     = dev_ctrl[DC_SRST]; // R19
	assign selected = drvhead[DH_DRIVE] == DRIVE_ID; // R24

	// next-state logic for registers and command engine
	always_comb begin
		next_dev_ctrl = dev_ctrl;
		next_seccnt   = seccnt;
		next_secnum   = secnum;
		next_cyl_lo   = cyl_lo;
		next_cyl_hi   = cyl_hi;
		next_drvhead  = drvhead;
		next_feature  = feature;
		next_status   = status;
		next_error    = error;
		next_irq_pend = irq_pend;
		next_state    = state;
		next_start    = 1'b0;
		next_opcode   = cmd_opcode;
		next_class    = cmd_class;
		if (wr_ctrl)
			next_dev_ctrl = s_dd;
		if (wr_blk0) begin
			next_dev_ctrl[DC_HOB] = 1'b0; // R17
			unique case (s_da)
				ADDR_FEATURE: next_feature = s_dd;
				ADDR_SECCNT:  next_seccnt  = s_dd;
				ADDR_SECNUM:  next_secnum  = s_dd;
				ADDR_CYL_LO:  next_cyl_lo  = s_dd;
				ADDR_CYL_HI:  next_cyl_hi  = s_dd;
				ADDR_DRVHEAD: next_drvhead = s_dd; // R11
				default:      next_drvhead = drvhead;
			endcase
		end
		next_status[ST_DRDY] = drive_ready;
		next_status[ST_DSC]  = drive_ready;
		// status read acks; alternate status read does not
		if (rd_stat)
			next_irq_pend = 1'b0; // R23
		// host written while busy is simply lost
		if (wr_cmd) begin
			next_irq_pend = 1'b0; // R4
			if (!status[ST_BSY] && drive_ready) begin // R1 R27
				next_opcode = s_dd;
				next_class  = decode_op(s_dd);
				next_status[ST_BSY] = 1'b1; // R25
				next_status[ST_ERR] = 1'b0;
				next_status[ST_DRQ] = 1'b0;
				next_error  = 8'h00;
				if (decode_op(s_dd) == ATACF_CL_BAD) begin
					next_state = ATACF_DONE; // R3
				end else begin
					next_start = 1'b1;
					next_state = ATACF_BUSY;
				end
			end
		end
		unique case (state)
			ATACF_IDLE: ;
			ATACF_BUSY: begin
				// busy ends at done, or early when data is requested
				if (cmd_drq) begin
					next_status[ST_BSY] = 1'b0; // R25
					next_status[ST_DRQ] = 1'b1;
				end
				if (cmd_done) begin
					next_status[ST_BSY] = 1'b0;
					next_status[ST_DRQ] = 1'b0;
					next_status[ST_ERR] = cmd_error;
					next_irq_pend = 1'b1;
					next_state    = ATACF_IDLE;
				end
			end
			ATACF_DONE: begin
				next_status[ST_BSY] = 1'b0; // R26
				next_status[ST_ERR] = 1'b1;
				next_error[ER_ABRT] = 1'b1;
				next_irq_pend = 1'b1;
				next_state    = ATACF_IDLE;
			end
		endcase
		// leaving soft reset frees busy, else the drive stays locked
		if (soft_reset && !srst)
			next_status[ST_BSY] = 1'b0; // R18
		// soft reset holds everything but device control
		if (srst) begin // R18
			next_seccnt   = SECCNT_RST;
			next_secnum   = SECCNT_RST;
			next_cyl_lo   = 8'h00;
			next_cyl_hi   = 8'h00;
			next_drvhead  = DRVHEAD_RST;
			next_feature  = 8'h00;
			next_error    = 8'h01;
			next_status   = 8'h80;
			next_irq_pend = 1'b0;
			next_state    = ATACF_IDLE;
			next_start    = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dev_ctrl   <= DEV_CTRL_RST;
			seccnt     <= SECCNT_RST;
			secnum     <= SECCNT_RST;
			cyl_lo     <= 8'h00;
			cyl_hi     <= 8'h00;
			drvhead    <= DRVHEAD_RST;
			feature    <= 8'h00;
			status     <= 8'h00;
			error      <= 8'h01;
			irq_pend   <= 1'b0;
			state      <= ATACF_IDLE;
			cmd_start  <= 1'b0;
			cmd_opcode <= 8'h00;
			cmd_class  <= ATACF_CL_BAD;
		end else begin
			dev_ctrl   <= next_dev_ctrl;
			seccnt     <= next_seccnt;
			secnum     <= next_secnum;
			cyl_lo     <= next_cyl_lo;
			cyl_hi     <= next_cyl_hi;
			drvhead    <= next_drvhead;
			feature    <= next_feature;
			status     <= next_status;
			error      <= next_error;
			irq_pend   <= next_irq_pend;
			state      <= next_state;
			cmd_start  <= next_start;
			cmd_opcode <= next_opcode;
			cmd_class  <= next_class;
		end
	end

	// output registers: read data, pin enables, parameter snapshot
	logic [7:0]  next_dd_out;
	logic        next_dd_oe, next_int_oe;
	logic [27:0] next_addr;
	always_comb begin
		next_dd_out = 8'h00;
		next_dd_oe  = 1'b0;
		if (!s_rd_b && selected && blk1 && s_da == ADDR_ALT_STAT) begin
			next_dd_out = status; // R16
			next_dd_oe  = 1'b1;
		end else if (!s_rd_b && selected && blk0) begin
			next_dd_oe = 1'b1;
			unique case (s_da)
				ADDR_ERROR:   next_dd_out = error;
				ADDR_SECCNT:  next_dd_out = seccnt;
				ADDR_SECNUM:  next_dd_out = secnum;
				ADDR_CYL_LO:  next_dd_out = cyl_lo;
				ADDR_CYL_HI:  next_dd_out = cyl_hi;
				ADDR_DRVHEAD: next_dd_out = drvhead;
				ADDR_STATUS:  next_dd_out = status;
				default:      next_dd_out = 8'h00; // data port not here
			endcase
		end
		// pin floats when disabled, drives when enabled and selected
		next_int_oe = !dev_ctrl[DC_NIEN] && selected; // R20 R21
		next_addr   = {drvhead[3:0], cyl_hi, cyl_lo, secnum}; // R11 R15
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dd_out      <= 8'h00;
			dd_oe       <= 1'b0;
			intrq_out   <= 1'b0;
			intrq_oe    <= 1'b0;
			cmd_address <= 28'h0000000;
			cmd_count   <= 8'h00;
			cmd_feature <= 8'h00;
			cmd_hob     <= 1'b0;
			soft_reset  <= 1'b0;
		end else begin
			dd_out      <= next_dd_out;
			dd_oe       <= next_dd_oe;
			intrq_out   <= irq_pend;
			intrq_oe    <= next_int_oe;
			cmd_address <= next_addr;
			cmd_count   <= seccnt; // R13
			cmd_feature <= feature; // R14
			cmd_hob     <= dev_ctrl[DC_HOB];
			soft_reset  <= srst; // R18
		end
	end
endmodule : atacf_front_end

// ==== verif/atacf_front_end_properties.sv ====
// port checker for the command-entry front end
// assumes it is bound onto atacf_front_end, drive clock only
`timescale 1ns/10ps
module atacf_front_end_properties (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    rst_b,
	// host bus
	input wire logic                    cs0_b,
	input wire logic                    cs1_b,
	input wire logic [2:0]              da,
	input wire logic                    dior_b,
	input wire logic                    diow_b,
	// results
	input wire logic                    intrq_out,
	input wire logic                    dd_oe,
	input wire logic                    cmd_start,
	input wire atacf_pkg::atacf_class_e cmd_class,
	input wire logic                    cmd_hob,
	input wire logic                    soft_reset,
	input wire logic                    cmd_done
);
	import atacf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// a start needs a command write still on the pins
	a_start_has_cause: assert property (cmd_start |-> !$past(diow_b)
		&& !$past(cs0_b) && $past(da) == 3'h7) else $error("stray start");
	a_start_valid_op: assert property (cmd_start |->
		cmd_class != ATACF_CL_BAD) else $error("bad opcode started");
	a_start_one_pulse: assert property (cmd_start |=> !cmd_start)
		else $error("start longer than one clock");
	a_srst_no_start: assert property (soft_reset |-> !cmd_start)
		else $error("start during soft reset");
	// command write drops the request within the sync lag
	a_cmd_drops_irq: assert property ($fell(diow_b) && !cs0_b && cs1_b
		&& da == 3'h7 |-> ##[3:6] !intrq_out) else $error("irq kept");
	a_status_acks: assert property ($fell(dior_b) && !cs0_b && cs1_b
		&& da == 3'h7 |-> ##[3:6] !intrq_out) else $error("no ack");
	a_alt_keeps_irq: assert property ($fell(dior_b) && !cs1_b && cs0_b
		&& da == 3'h6 && intrq_out |-> ##5 intrq_out) else $error("alt ack");
	a_hob_cleared: assert property ($fell(diow_b) && !cs0_b && cs1_b
		|-> ##[1:6] !cmd_hob) else $error("hob not cleared");
	a_done_raises: assert property (cmd_done |-> ##[1:3] intrq_out)
		else $error("no irq after done");
	a_oe_only_read: assert property (dd_oe |-> !$past(dior_b, 3))
		else $error("bus driven without read");
endmodule : atacf_front_end_properties

bind atacf_front_end atacf_front_end_properties u_props (.clk, .rst_b,
	.cs0_b, .cs1_b, .da, .dior_b, .diow_b, .intrq_out, .dd_oe, .cmd_start,
	.cmd_class, .cmd_hob, .soft_reset, .cmd_done);

// ==== verif/atacf_host_model.sv ====
// host adapter model driving the task-file register bus
// assumes read data stands 3 clocks into the strobe
`timescale 1ns/10ps
module atacf_host_model (
	// clock
	input wire logic        clk,
	// read data from the device
	input wire logic [7:0]  dd_out,
	// bus toward the device
	output logic            cs0_b,
	output logic            cs1_b,
	output logic [2:0]      da,
	output logic            dior_b,
	output logic            diow_b,
	output logic [7:0]      dd_in
);
	initial begin
		{cs0_b, cs1_b, dior_b, diow_b} = 4'hF;
		da = 3'h0;
		dd_in = 8'h00;
	end
	// strobe held 4 clocks, gap 5; released data inverted, not held
	task automatic acc(input bit c1, input bit w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#2;
		{cs0_b, cs1_b, da, dd_in} = {c1, !c1, a, d};
		if (w) diow_b = 1'b0;
		else dior_b = 1'b0;
		repeat (4) @(posedge clk);
		q = dd_out;
		#2;
		{cs0_b, cs1_b, dior_b, diow_b, dd_in} = {4'hF, ~d};
		repeat (4) @(posedge clk);
	endtask : acc
	task automatic wr(input bit c1, input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(c1, 1'b1, a, d, q);
	endtask : wr
	task automatic rd(input bit c1, input logic [2:0] a, output logic [7:0] q);
		acc(c1, 1'b0, a, 8'h00, q);
	endtask : rd
	// alternate status polled so no interrupt is acknowledged
	task automatic cmd(input logic [7:0] op);
		logic [7:0] s;
		s = 8'h80;
		for (int i = 0; i < 20 && s[7:6] != 2'b01; i++) rd(1'b1, 3'h6, s);
		wr(1'b0, 3'h7, op);
	endtask : cmd
endmodule : atacf_host_model

// ==== verif/ata_command_register_front_end_tb_top.sv ====
// self-checking bench for the command-entry front end
// assumes drive 0 and a back end that finishes 30 clocks after start
`timescale 1ns/10ps
module ata_command_register_front_end_tb_top;
	import atacf_pkg::*;
	logic clk = 0, rst_b = 0, drive_ready = 1, cmd_done = 0;
	logic cs0_b, cs1_b, dior_b, diow_b, dd_oe, intrq_out, intrq_oe;
	logic cmd_start, cmd_hob, soft_reset;
	logic [2:0] da;
	logic [7:0] dd_in, dd_out, cmd_opcode, cmd_count, cmd_feature, s;
	logic [7:0] tf [7];
	logic [27:0] cmd_address;
	logic [31:0] rnd = 32'h521E;
	atacf_class_e cmd_class;
	int fails = 0, comparisons = 0, starts = 0, oe_cycles = 0, n, e;
	always #25 clk = ~clk;
	atacf_front_end u_dut (.clk, .rst_b, .cs0_b, .cs1_b, .da, .dior_b,
		.diow_b, .dd_in, .dd_out, .dd_oe, .intrq_out, .intrq_oe,
		.drive_ready, .cmd_start, .cmd_opcode, .cmd_class, .cmd_address,
		.cmd_count, .cmd_feature, .cmd_hob, .soft_reset, .cmd_done,
		.cmd_error(1'b0), .cmd_drq(1'b0));
	atacf_host_model u_host (.clk, .dd_out, .cs0_b, .cs1_b, .da, .dior_b,
		.diow_b, .dd_in);
	// back end stand-in; counts starts, finishes one at a time
	always @(posedge clk) if (cmd_start === 1'b1) starts++;
	// clocks with the data bus driven, a read should give four
	always @(posedge clk) if (dd_oe === 1'b1) oe_cycles++;
	always begin
		@(posedge clk iff cmd_start === 1'b1);
		repeat (30) @(posedge clk);
		#2 cmd_done = 1;
		@(posedge clk);
		#2 cmd_done = 0;
	end
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	// expected class from the parameters each code consumes
	function automatic int cls(logic [7:0] o);
		case (o) inside
			8'h00, [8'h10:8'h1F], 8'h90, 8'h27, 8'hE4, 8'hE7, 8'hE8,
			8'hEA, 8'hEC, [8'hF1:8'hF6], 8'hF8: return 1;
			8'h50, [8'h70:8'h7F]: return 3;
			8'h91, 8'hC6, [8'hE0:8'hE3], 8'hE5, 8'hE6, [8'h94:8'h99]: return 4;
			8'hEF, 8'hB0, 8'hB1, 8'hFC: return 5;
			8'h92: return 6;
			8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'h30, 8'h31, 8'h34, 8'h35,
			8'h37, 8'h39, 8'h3C, [8'h40:8'h42], 8'hC4, 8'hC5, [8'hC8:8'hCB],
			8'hF9: return 2;
			default: return 0;
		endcase
	endfunction : cls
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic idle_wait();
		s = 8'h80;
		for (int i = 0; i < 20 && s[7]; i++) u_host.rd(1'b1, 3'h6, s);
	endtask : idle_wait
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		end_of_test();
	end
	// every opcode in turn, then the refusals and control bits
	initial begin
		repeat (8) @(posedge clk);
		#2 rst_b = 1;
		u_host.wr(1'b1, 3'h6, 8'h08);
		for (int op = 0; op < 256; op++) begin
			for (int i = 1; i < 7; i++) begin
				rnd = xs(rnd);
				tf[i] = rnd[7:0];
			end
			tf[6] = {4'hA, tf[6][3:0]};
			for (int i = 1; i < 7; i++) u_host.wr(1'b0, i[2:0], tf[i]);
			n = starts;
			e = cls(op[7:0]);
			u_host.cmd(op[7:0]);
			chk("start", starts - n, e != 0);
			if (e != 0) chk("opcode", cmd_opcode, op);
			if (e != 0) chk("class", cmd_class, e);
			if (e == 2 || e == 3) chk("address", cmd_address,
				{tf[6][3:0], tf[5], tf[4], tf[3]});
			if (e == 2 || e == 4 || e == 6) chk("count", cmd_count, tf[2]);
			if (e == 5) chk("feature", cmd_feature, tf[1]);
			idle_wait();
			chk("pending", intrq_out, 1);
			chk("pin on", intrq_oe, 1);
			u_host.rd(1'b0, 3'h1, s);
			chk("error", s, {5'h00, e == 0, 2'h0});
			n = oe_cycles;
			u_host.rd(1'b0, 3'h7, s);
			chk("read drive", oe_cycles - n, 4);
			chk("status", s & 8'hC9, 8'h40 | (e == 0));
			chk("acked", intrq_out, 0);
		end
		n = starts;
		u_host.wr(1'b0, 3'h7, 8'h20);
		u_host.wr(1'b0, 3'h7, 8'h30);
		chk("busy write", starts - n, 1);
		idle_wait();
		#2 drive_ready = 0;
		u_host.wr(1'b0, 3'h7, 8'h20);
		chk("not ready", starts - n, 1);
		chk("dropped", intrq_out, 0);
		#2 drive_ready = 1;
		u_host.wr(1'b1, 3'h6, 8'h88);
		chk("hob set", cmd_hob, 1);
		u_host.wr(1'b0, 3'h2, 8'h05);
		chk("hob clear", cmd_hob, 0);
		u_host.wr(1'b1, 3'h6, 8'h0A);
		chk("float", intrq_oe, 0);
		u_host.wr(1'b1, 3'h6, 8'h08);
		u_host.wr(1'b0, 3'h6, 8'hB0);
		chk("other drive", intrq_oe, 0);
		n = oe_cycles;
		u_host.rd(1'b0, 3'h7, s);
		chk("quiet bus", oe_cycles - n, 0);
		u_host.wr(1'b1, 3'h6, 8'h0C);
		chk("soft reset", soft_reset, 1);
		u_host.rd(1'b1, 3'h6, s);
		chk("held busy", s, 8'h80);
		u_host.wr(1'b1, 3'h6, 8'h08);
		u_host.rd(1'b0, 3'h6, s);
		chk("drvhead reset", s, 8'hA0);
		u_host.rd(1'b1, 3'h6, s);
		chk("reset over", s, 8'h50);
		end_of_test();
	end
endmodule : ata_command_register_front_end_tb_top
